// ==== clock_gate_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Byte addresses on a 32-bit APB, one register per word.
// Notes:   Definitions only.
`ifndef CLOCK_GATE_PARAMS_SVH
`define CLOCK_GATE_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_RESET_CAUSE   12'h008
`define OFS_SLOW_WINDOW   12'h00C
`define OFS_SLOW_PERIOD   12'h010
`define OFS_MEAS_FREQ_RESULT     12'h014
`define OFS_MEAS_IRQ      12'h018
`define OFS_CLK_GATE      12'h020
`define OFS_DMA_ROUTE     12'h024
`define OFS_MEAS_IRQ_MASK 12'h028

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define RST_CLK_GATE      18'h3_FFFF
`define CLK_GATE_WR_MASK  18'h3_3F9F
`define CLK_GATE_RSV_ONES 32'h0000_C060
`define RST_DMA_ROUTE     8'h00
`define RST_CAUSE         11'h005
`define CAUSE_BROWNOUT    1
`define CAUSE_WAKE_PIN    3
`define CAUSE_RADIO1      8
`define CAUSE_RADIO2      10
`define RST_WINDOW        9'h00F
`define AUTO_WINDOW       9'h010
`define RST_IRQ_MASK      1'b1

// ****************************************************************
// Timing: the result counts half-periods of 16 MHz, i.e. 32 MHz ticks
// ****************************************************************
`define PCLK_MHZ          7'd125
`define TICK_MHZ          7'd32
`define PERIOD_MAX        19'h7_FFFF
`define DIV_STEPS         6'd34
`define DIV_TOP_BIT       6'd33

`endif

// ==== clock_gate_pkg.sv ====
// Purpose: Types shared by the clock gating and slow clock measurement block.
// Assumes: Constants live in clock_gate_params.svh.
// Notes:   All module state is one packed struct.
package clock_gate_pkg;

   typedef enum logic [1:0] {
      MEAS_IDLE,
      MEAS_ARM,
      MEAS_COUNT,
      MEAS_DIVIDE
   } meas_fsm_t;

   typedef struct packed {
      logic            wake_pin_e;
      logic            wake_pin_d;
      logic            wake_pin_c;
      logic            wake_pin_b;
      logic            wake_pin_a;
      logic            wake_radio_timer2;
      logic            wake_radio_timer1;
      logic            brownout;
   } wake_events_t;

   typedef struct packed {
      logic [17:0]     clk_gate;
      logic [7:0]      dma_route;
      logic [10:0]     cause;
      logic [8:0]      window;
      logic [18:0]     period;
      logic [26:0]     freq;
      logic            pending;
      logic            mask;
      meas_fsm_t       fsm;
      logic [8:0]      win_len;
      logic [8:0]      edges;
      logic [18:0]     ticks;
      logic [6:0]      acc;
      logic            slow_prev;
      logic            active_prev;
      logic [19:0]     div_rem;
      logic [26:0]     div_quo;
      logic [5:0]      div_cnt;
      logic [31:0]     rdata;
      logic            slverr;
   } state_t;

endpackage

// ==== clock_gate_meas.sv ====
// Purpose: Peripheral clock gating, converter DMA routing, reset and
//          wakeup cause capture, and slow clock measurement over APB.
// Assumes: All inputs are synchronous to pclk; slow_clk is sampled.
// Notes:   Zero wait-state APB slave; read data is captured at setup.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`include "clock_gate_params.svh"

//  Overview of operation
// - One clock enable per peripheral, set at reset.
// - Routing bit n puts converter on channel n.
// - Several routing bits may be set together.
// - Cause register flags brownout, power-on; reads 0x5.
// - Five wake pins recorded in bits 3 to 7.
// - Radio timers 1 and 2 in bits 8, 10.
// - Nine-bit window length, reset value 0xF.
// - Period result counts 16 MHz half-periods.
// - Entering second active state measures sixteen periods.
// - Writing zero to period starts programmed measurement.
// - Frequency equals two to 33 over period.
// - Interrupt bit reads one while measurement pending.
// - Writing one clears pending; zero has no effect.
module clock_gate_meas (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      slow_clk,
   input  wire logic                      second_active_state,
   input  wire clock_gate_pkg::wake_events_t wake_events,
   output logic      [17:0]               periph_clk_en,
   output logic      [7:0]                converter_dma_sel,
   output logic                           meas_irq
);

   clock_gate_pkg::state_t s_q;
   clock_gate_pkg::state_t s_d;

   logic        wr_en;
   logic        rd_setup;
   logic        slow_rise;
   logic        tick;
   logic        meas_done;
   logic        start_auto;
   logic        start_sw;
   logic        any_event;
   logic [7:0]  acc_sum;
   logic [19:0] rem_shift;
   logic [10:0] cause_new;
   logic [31:0] rd_val;
   logic        rd_hit;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign pready   = 1'b1;
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign prdata   = s_q.rdata;
   assign pslverr  = s_q.slverr & psel & penable;

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == `OFS_CLK_GATE) begin
         rd_val = {14'h0000, s_q.clk_gate} | `CLK_GATE_RSV_ONES;
      end else if (paddr == `OFS_DMA_ROUTE) begin
         rd_val = {24'h00_0000, s_q.dma_route};
      end else if (paddr == `OFS_RESET_CAUSE) begin
         rd_val = {21'h00_0000, s_q.cause};
      end else if (paddr == `OFS_SLOW_WINDOW) begin
         rd_val = {23'h00_0000, s_q.window};
      end else if (paddr == `OFS_SLOW_PERIOD) begin
         rd_val = {13'h0000, s_q.period};
      end else if (paddr == `OFS_MEAS_FREQ_RESULT) begin
         rd_val = {5'h00, s_q.freq};
      end else if (paddr == `OFS_MEAS_IRQ) begin
         rd_val = {31'h0000_0000, s_q.pending};
      end else if (paddr == `OFS_MEAS_IRQ_MASK) begin
         rd_val = {31'h0000_0000, s_q.mask};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ****************************************************************
   // Event detection
   // ****************************************************************
   // The 32 MHz tick comes from a fractional accumulator because 125 MHz
   // is no integer multiple of it; each tick is off by under one pclk.
   assign acc_sum    = {1'b0, s_q.acc} + {1'b0, `TICK_MHZ};
   assign tick       = acc_sum >= {1'b0, `PCLK_MHZ};
   assign slow_rise  = slow_clk & ~s_q.slow_prev;
   assign start_auto = second_active_state & ~s_q.active_prev;
   assign start_sw   = wr_en & (paddr == `OFS_SLOW_PERIOD)
                       & (pwdata == 32'h0000_0000);
   assign meas_done  = (s_q.fsm == clock_gate_pkg::MEAS_DIVIDE)
                       & (s_q.div_cnt == 6'd0);
   assign any_event  = |wake_events;
   assign rem_shift  = {s_q.div_rem[18:0], s_q.div_cnt == `DIV_TOP_BIT};

   always_comb begin
      cause_new = 11'h001;
      cause_new[`CAUSE_BROWNOUT] = wake_events.brownout;
      cause_new[`CAUSE_WAKE_PIN + 0] = wake_events.wake_pin_a;
      cause_new[`CAUSE_WAKE_PIN + 1] = wake_events.wake_pin_b;
      cause_new[`CAUSE_WAKE_PIN + 2] = wake_events.wake_pin_c;
      cause_new[`CAUSE_WAKE_PIN + 3] = wake_events.wake_pin_d;
      cause_new[`CAUSE_WAKE_PIN + 4] = wake_events.wake_pin_e;
      cause_new[`CAUSE_RADIO1] = wake_events.wake_radio_timer1;
      cause_new[`CAUSE_RADIO2] = wake_events.wake_radio_timer2;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.slow_prev   = slow_clk;
      s_d.active_prev = second_active_state;
      s_d.acc = tick ? 7'(acc_sum - {1'b0, `PCLK_MHZ}) : acc_sum[6:0];
      if (rd_setup) begin
         s_d.rdata  = pwrite ? s_q.rdata : rd_val;
         s_d.slverr = ~rd_hit;
      end
      if (wr_en) begin
         if (paddr == `OFS_CLK_GATE) begin
            s_d.clk_gate = pwdata[17:0] & `CLK_GATE_WR_MASK;
         end else if (paddr == `OFS_DMA_ROUTE) begin
            // Overlapping routes are allowed; the DMA side arbitrates.
            s_d.dma_route = pwdata[7:0];
         end else if (paddr == `OFS_SLOW_WINDOW) begin
            s_d.window = pwdata[8:0];
         end else if (paddr == `OFS_MEAS_IRQ_MASK) begin
            s_d.mask = pwdata[0];
         end else if (paddr == `OFS_MEAS_IRQ) begin
            if (pwdata[0]) begin
               s_d.pending = 1'b0;
            end
         end
      end
      if (any_event) begin
         s_d.cause = cause_new;
      end
      case (s_q.fsm)
         clock_gate_pkg::MEAS_IDLE: begin
         end
         clock_gate_pkg::MEAS_ARM: begin
            if (slow_rise) begin
               s_d.fsm   = clock_gate_pkg::MEAS_COUNT;
               s_d.ticks = 19'h0_0000;
               s_d.edges = 9'h000;
            end
         end
         clock_gate_pkg::MEAS_COUNT: begin
            if (tick && s_q.ticks != `PERIOD_MAX) begin
               s_d.ticks = s_q.ticks + 19'h0_0001;
            end
            if (slow_rise) begin
               s_d.edges = s_q.edges + 9'h001;
               if (s_q.edges + 9'h001 >= s_q.win_len) begin
                  s_d.fsm     = clock_gate_pkg::MEAS_DIVIDE;
                  s_d.div_rem = 20'h0_0000;
                  s_d.div_quo = 27'h000_0000;
                  s_d.div_cnt = `DIV_TOP_BIT;
               end
            end
         end
         clock_gate_pkg::MEAS_DIVIDE: begin
            // One restoring step per cycle keeps the divider small.
            if (rem_shift >= {1'b0, s_q.ticks} && s_q.ticks != 19'h0_0000) begin
               s_d.div_rem = rem_shift - {1'b0, s_q.ticks};
               s_d.div_quo = {s_q.div_quo[25:0], 1'b1};
            end else begin
               s_d.div_rem = rem_shift;
               s_d.div_quo = {s_q.div_quo[25:0], 1'b0};
            end
            s_d.div_cnt = s_q.div_cnt - 6'd1;
            if (meas_done) begin
               s_d.fsm     = clock_gate_pkg::MEAS_IDLE;
               s_d.period  = s_q.ticks;
               s_d.freq    = s_d.div_quo;
               s_d.pending = 1'b1;
            end
         end
         default: begin
            s_d.fsm = clock_gate_pkg::MEAS_IDLE;
         end
      endcase
      if (start_auto) begin
         s_d.fsm     = clock_gate_pkg::MEAS_ARM;
         s_d.win_len = `AUTO_WINDOW;
      end else if (start_sw) begin
         s_d.fsm     = clock_gate_pkg::MEAS_ARM;
         s_d.win_len = s_q.window;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q           <= '0;
         s_q.clk_gate  <= `RST_CLK_GATE;
         s_q.dma_route <= `RST_DMA_ROUTE;
         s_q.cause     <= `RST_CAUSE;
         s_q.window    <= `RST_WINDOW;
         s_q.mask      <= `RST_IRQ_MASK;
         s_q.fsm       <= clock_gate_pkg::MEAS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign periph_clk_en     = s_q.clk_gate;
   assign converter_dma_sel = s_q.dma_route;
   assign meas_irq          = s_q.pending & s_q.mask;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_write(logic [11:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence

   property p_gate_write;
      s_write(`OFS_CLK_GATE) |=> periph_clk_en == ($past(pwdata[17:0]) & 18'h3_3F9F);
   endproperty
   a_gate_write: assert property (p_gate_write) else $error("clock gate write lost");

   property p_route_write;
      s_write(`OFS_DMA_ROUTE) |=> converter_dma_sel == $past(pwdata[7:0]);
   endproperty
   a_route_write: assert property (p_route_write) else $error("route write lost");

   property p_wake_capture;
      any_event |=> s_q.cause == {$past(wake_events.wake_radio_timer2), 1'b0,
                    $past(wake_events.wake_radio_timer1), $past(wake_events[7:3]),
                    1'b0, $past(wake_events.brownout), 1'b1};
   endproperty
   a_wake_capture: assert property (p_wake_capture) else $error("wake cause wrong");

   property p_window_write;
      s_write(`OFS_SLOW_WINDOW) |=> s_q.window == $past(pwdata[8:0]);
   endproperty
   a_window_write: assert property (p_window_write) else $error("window write lost");

   property p_auto_start;
      start_auto |=> s_q.fsm == clock_gate_pkg::MEAS_ARM && s_q.win_len == 9'h010;
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("auto start wrong");

   property p_sw_start;
      start_sw && !start_auto |=> s_q.fsm == clock_gate_pkg::MEAS_ARM
                                  && s_q.win_len == $past(s_q.window);
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("software start wrong");

   sequence s_finish;
      meas_done ##1 s_q.pending;
   endsequence

   property p_done_sets;
      meas_done |-> s_finish;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("pending not set");

   property p_clear_one;
      wr_en && paddr == `OFS_MEAS_IRQ && pwdata[0] && !meas_done |=> !s_q.pending ##0 !meas_irq;
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("clear failed");

   property p_write_zero;
      wr_en && paddr == `OFS_MEAS_IRQ && !pwdata[0] && !meas_done
         |=> s_q.pending == $past(s_q.pending);
   endproperty
   a_write_zero: assert property (p_write_zero) else $error("zero write changed flag");

   property p_divide_len;
      $rose(s_q.fsm == clock_gate_pkg::MEAS_DIVIDE) && !start_auto && !start_sw
         |-> ##33 meas_done || start_auto || start_sw || $past(start_auto || start_sw);
   endproperty
   a_divide_len: assert property (p_divide_len) else $error("divide length wrong");

   // ****************************************************************
   // Result checks
   // ****************************************************************
   // The quotient is multiplied back instead of divided again, so a
   // mistake shared by two dividers cannot hide. Periods up to 64 ticks
   // overflow the 27-bit field and are left out on purpose.
   sequence s_result_ready;
      meas_done ##1 s_q.period > 19'd64;
   endsequence

   property p_freq_value;
      s_result_ready |-> 64'(s_q.freq) * 64'(s_q.period) <= 64'h2_0000_0000
         && (64'(s_q.freq) + 64'd1) * 64'(s_q.period) > 64'h2_0000_0000;
   endproperty
   a_freq_value: assert property (p_freq_value) else $error("frequency wrong");

   property p_period_new;
      meas_done |=> s_q.period == $past(s_q.ticks);
   endproperty
   a_period_new: assert property (p_period_new) else $error("period stale");

   property p_irq_rise;
      meas_done && s_q.mask && !(wr_en && paddr == `OFS_MEAS_IRQ_MASK) |=> meas_irq;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt not raised");

   property p_period_ro;
      wr_en && paddr == `OFS_SLOW_PERIOD && pwdata != 32'h0000_0000 && !meas_done
         |=> s_q.period == $past(s_q.period);
   endproperty
   a_period_ro: assert property (p_period_ro) else $error("period overwritten");

   // ****************************************************************
   // Measurement steps
   // ****************************************************************
   property p_arm_step;
      s_q.fsm == clock_gate_pkg::MEAS_ARM && slow_rise && !start_auto && !start_sw
         |=> s_q.fsm == clock_gate_pkg::MEAS_COUNT && s_q.ticks == 19'h0_0000;
   endproperty
   a_arm_step: assert property (p_arm_step) else $error("count not started");

   property p_count_end;
      s_q.fsm == clock_gate_pkg::MEAS_COUNT && slow_rise && !start_auto && !start_sw
         && s_q.edges + 9'h001 >= s_q.win_len
         |=> s_q.fsm == clock_gate_pkg::MEAS_DIVIDE && s_q.div_cnt == `DIV_TOP_BIT;
   endproperty
   a_count_end: assert property (p_count_end) else $error("window end missed");

   // A saturated count stays put, so a slow clock period too long for the counter reads as the longest period.
   property p_ticks_sat;
      s_q.fsm == clock_gate_pkg::MEAS_COUNT && s_q.ticks == `PERIOD_MAX
         |=> s_q.ticks == `PERIOD_MAX;
   endproperty
   a_ticks_sat: assert property (p_ticks_sat) else $error("period wrapped");

   // ****************************************************************
   // Hold checks
   // ****************************************************************
   // The gate, route and window registers move only on their own write, so a decode slip shows at once.
   property p_gate_hold;
      !(wr_en && paddr == `OFS_CLK_GATE) |=> $stable(periph_clk_en);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("clock gate moved");

   property p_route_hold;
      !(wr_en && paddr == `OFS_DMA_ROUTE) |=> $stable(converter_dma_sel);
   endproperty
   a_route_hold: assert property (p_route_hold) else $error("route moved");

   property p_window_hold;
      !(wr_en && paddr == `OFS_SLOW_WINDOW) |=> $stable(s_q.window);
   endproperty
   a_window_hold: assert property (p_window_hold) else $error("window moved");

   // The cause register ignores writes; only a wake event replaces it.
   property p_cause_hold;
      !any_event |=> s_q.cause == $past(s_q.cause);
   endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("cause moved");

endmodule

// ==== testbench.sv ====
// Purpose: Bench for clock gating, routing, cause capture and slow clock measurement.
// Assumes: Slow clock is made here with a period of 250 pclk cycles, i.e. 64 ticks of 32 MHz.
// Notes:   Period results allow a small tolerance for tick jitter and edge sampling.
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic        err;
   } row_t;
   localparam int SLOW_TICKS = 64;
   logic                         pclk, presetn, psel, penable, pwrite;
   logic                         second_active_state, pready, pslverr, meas_irq, err;
   logic                         slow_clk = 1'b0;
   logic [11:0]                  paddr;
   logic [31:0]                  pwdata, prdata, rd, per;
   logic [3:0]                   pstrb;
   logic [17:0]                  periph_clk_en;
   logic [7:0]                   converter_dma_sel;
   logic [7:0]                   slow_cnt = 8'h00;
   clock_gate_pkg::wake_events_t wake_events;
   int                           errors, checked, pos [8];
   row_t                         rows [9];

   clock_gate_meas uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slow_clk(slow_clk),
      .second_active_state(second_active_state), .wake_events(wake_events),
      .periph_clk_en(periph_clk_en), .converter_dma_sel(converter_dma_sel),
      .meas_irq(meas_irq));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // The slow clock runs free, as a crystal oscillator would.
   always @(posedge pclk) begin
      if (slow_cnt == 8'h7C) begin
         slow_cnt <= 8'h00;
         slow_clk <= ~slow_clk;
      end else begin
         slow_cnt <= slow_cnt + 8'h01;
      end
   end

   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk_range(input string name, input logic [31:0] lo, input logic [31:0] hi,
                  input logic [31:0] got);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("unexpected %s expected %h to %h seen %h", name, lo, hi, got);
      end
   endtask

   // The answer is taken at the rising edge that ends the access, before that edge's
   // updates land, so it is what the slave showed while the edge sampled it.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] data, output logic fault);
      int n;
      logic rdy;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      rdy = 1'b0;
      for (n = 0; n < 16 && rdy !== 1'b1; n++) begin
         @(posedge pclk);
         rdy   = pready;
         data  = prdata;
         fault = pslverr;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      if (rdy !== 1'b1) begin
         errors++;
         $display("unexpected pready expected 1 seen timeout");
         complete_run();
      end
   endtask

   task wait_irq;
      int n;
      for (n = 0; n < 20000 && meas_irq !== 1'b1; n++)
         @(negedge pclk);
      if (meas_irq !== 1'b1) begin
         errors++;
         $display("unexpected meas_irq expected 1 seen timeout");
         complete_run();
      end
   endtask

   initial begin
      errors = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      second_active_state = 1'b0;
      wake_events = '0;
      pos = '{1, 8, 10, 3, 4, 5, 6, 7};
      rows = '{{12'h008, 32'h0000_0005, 1'b0}, {12'h00C, 32'h0000_000F, 1'b0},
               {12'h010, 32'h0000_0000, 1'b0}, {12'h014, 32'h0000_0000, 1'b0},
               {12'h018, 32'h0000_0000, 1'b0}, {12'h020, 32'h0003_FFFF, 1'b0},
               {12'h024, 32'h0000_0000, 1'b0}, {12'h028, 32'h0000_0001, 1'b0},
               {12'h030, 32'h0000_0000, 1'b1}};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("periph_clk_en", 32'h0003_FFFF, {14'h0000, periph_clk_en});
      chk("converter_dma_sel", 32'h0000_0000, {24'h00_0000, converter_dma_sel});
      foreach (rows[i]) begin
         apb(1'b0, rows[i].addr, 32'h0000_0000, rd, err);
         chk("prdata", rows[i].data, rd);
         chk("pslverr", {31'h0, rows[i].err}, {31'h0, err});
      end
      $display("test reset values done");

      apb(1'b1, 12'h020, 32'h0000_0000, rd, err);
      @(negedge pclk);
      chk("periph_clk_en", 32'h0000_0000, {14'h0000, periph_clk_en});
      apb(1'b1, 12'h020, 32'hFFFF_FFFF, rd, err);
      @(negedge pclk);
      chk("periph_clk_en", 32'h0003_3F9F, {14'h0000, periph_clk_en});
      apb(1'b0, 12'h020, 32'h0000_0000, rd, err);
      chk("clock gate read", 32'h0003_FFFF, rd);
      apb(1'b1, 12'h024, 32'hFFFF_FFFF, rd, err);
      @(negedge pclk);
      chk("converter_dma_sel", 32'h0000_00FF, {24'h00_0000, converter_dma_sel});
      apb(1'b1, 12'h024, 32'h0000_0080, rd, err);
      apb(1'b0, 12'h024, 32'h0000_0000, rd, err);
      chk("route read", 32'h0000_0080, rd);
      $display("test gating and routing done");

      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         wake_events <= 8'h01 << i;
         @(posedge pclk);
         wake_events <= '0;
         apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, err);
         apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
         chk("cause", 32'h0000_0001 | (32'h0000_0001 << pos[i]), rd);
      end
      $display("test wake causes done");

      apb(1'b1, 12'h00C, 32'hFFFF_FFFF, rd, err);
      apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
      chk("window", 32'h0000_01FF, rd);
      apb(1'b1, 12'h00C, 32'h0000_0003, rd, err);
      apb(1'b1, 12'h010, 32'h0000_0000, rd, err);
      wait_irq();
      apb(1'b0, 12'h010, 32'h0000_0000, per, err);
      chk_range("period", 3 * SLOW_TICKS - 2, 3 * SLOW_TICKS + 2, per);
      apb(1'b0, 12'h014, 32'h0000_0000, rd, err);
      chk("freq", 32'((64'h2_0000_0000 / per) & 64'h7FF_FFFF), rd);
      apb(1'b1, 12'h010, 32'h0000_0005, rd, err);
      apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
      chk("period kept", per, rd);
      $display("test programmed measurement done");

      apb(1'b1, 12'h018, 32'h0000_0000, rd, err);
      apb(1'b0, 12'h018, 32'h0000_0000, rd, err);
      chk("pending", 32'h0000_0001, rd);
      apb(1'b1, 12'h028, 32'h0000_0000, rd, err);
      @(negedge pclk);
      chk("meas_irq masked", 32'h0000_0000, {31'h0, meas_irq});
      apb(1'b1, 12'h028, 32'h0000_0001, rd, err);
      @(negedge pclk);
      chk("meas_irq", 32'h0000_0001, {31'h0, meas_irq});
      apb(1'b1, 12'h018, 32'h0000_0001, rd, err);
      apb(1'b0, 12'h018, 32'h0000_0000, rd, err);
      chk("pending cleared", 32'h0000_0000, rd);
      chk("meas_irq cleared", 32'h0000_0000, {31'h0, meas_irq});
      $display("test interrupt done");

      @(posedge pclk);
      second_active_state <= 1'b1;
      wait_irq();
      apb(1'b0, 12'h010, 32'h0000_0000, per, err);
      chk_range("auto period", 16 * SLOW_TICKS - 2, 16 * SLOW_TICKS + 2, per);
      $display("test automatic measurement done");

      // A reset in mid-measurement must bring periph_clk_en and meas_irq back to their reset values.
      apb(1'b1, 12'h010, 32'h0000_0000, rd, err);
      repeat (300) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("periph_clk_en", 32'h0003_FFFF, {14'h0000, periph_clk_en});
      chk("meas_irq", 32'h0000_0000, {31'h0, meas_irq});
      // The processor-side cause is taken as zero here, so this register is the one to read.
      apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
      chk("cause", 32'h0000_0005, rd);
      $display("test reset in mid-run done");
      complete_run();
   end
endmodule
